//--- verilog/lcc_pkg.sv
// Constants, field layout and state types of the line-chip control block.
// Assumes a 100 MHz master clock and a 32-bit APB register bus.
package lcc_pkg;
	// Clock and timing
	localparam int CLK_MHZ       = 100;
	localparam int HOLD_NS       = 20000;
	localparam int PD_HOLD_NS    = 200;
	localparam int DEB_STEP_US   = 1000;
	localparam int TMR_W         = 24;
	localparam int HOLD_CYC_I    = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int PD_HOLD_CYC_I = (PD_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int DEB_STEP_CYC  = DEB_STEP_US * CLK_MHZ;
	localparam logic [TMR_W-1:0] HOLD_CYC    = TMR_W'(HOLD_CYC_I);
	localparam logic [TMR_W-1:0] PD_HOLD_CYC = TMR_W'(PD_HOLD_CYC_I);
	localparam logic [TMR_W-1:0] TMR_ONE     = 24'h000001;
	localparam logic [TMR_W-1:0] TMR_ZERO    = 24'h000000;

	// Register byte offsets
	localparam int          ADDR_W   = 12;
	localparam logic [11:0] OFF_MODE = 12'h000;
	localparam logic [11:0] OFF_DEBT = 12'h004;
	localparam logic [11:0] OFF_LC1  = 12'h008;
	localparam logic [11:0] OFF_LC2  = 12'h00C;

	// basic_mode_reg fields
	localparam int MODE_CH1_ACT = 0;
	localparam int MODE_CH2_ACT = 1;
	localparam int MODE_A_LAW_SEL    = 2;
	localparam int MODE_LIN     = 3;
	// chN_line_control fields
	localparam int LC_STATE_LSB = 5;
	localparam int LC_AUXSW     = 4;
	localparam int LC_BATT      = 3;
	localparam int LC_EVSEL     = 2;
	localparam int LC_EVSTAT    = 1;
	// debounce_timer_reg fields, four bits per channel
	localparam int DEBT_CH1_LSB = 0;
	localparam int DEBT_CH2_LSB = 4;

	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] DEBT_RST = 8'h00;
	localparam logic [7:0] LC_RST   = 8'h00;
	localparam logic [3:0] MULT_ONE = 4'h1;

	// Power-save slot codes
	localparam logic [7:0]  MU_IDLE  = 8'hFF;
	localparam logic [7:0]  A_IDLE   = 8'hD5;
	localparam logic [13:0] LIN_IDLE = 14'h0000;
	localparam logic [5:0]  PAD8     = 6'h00;

	typedef enum logic [1:0] {
		LCC_DB_HIGH = 2'b00,
		LCC_DB_WAIT = 2'b01,
		LCC_DB_LOW  = 2'b11
	} lcc_db_t;
endpackage

//--- verilog/lcc_ch_if.sv
// Signals between the control top and one per-channel timer unit.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
interface lcc_ch_if;
	logic       power_down;
	logic       evsel_bit;
	logic [3:0] deb_bits;
	logic       event_in_n;
	logic       evsel_out;
	logic       event_status;

	modport ctl  (output power_down, evsel_bit, deb_bits, event_in_n,
	              input  evsel_out, event_status);
	modport chan (input  power_down, evsel_bit, deb_bits, event_in_n,
	              output evsel_out, event_status);
endinterface

//--- verilog/lcc_chan.sv
// Per-channel event-select hold timer and event-input debounce.
// Assumes event_in_n is already synchronised to the master clock.
`timescale 1ns/1ps
module lcc_chan #(
	parameter int unsigned DEB_STEP_CYC = lcc_pkg::DEB_STEP_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	lcc_ch_if.chan    ch
);
	typedef struct packed {
		logic [lcc_pkg::TMR_W-1:0] hold_cnt;
		logic                      evsel_tgt;
		logic                      evsel_out;
		logic [lcc_pkg::TMR_W-1:0] deb_cnt;
		logic [3:0]                deb_mult;
		lcc_pkg::lcc_db_t          db;
		logic                      status;
	} lcc_chan_st_t;

	localparam logic [lcc_pkg::TMR_W-1:0] STEP_M1 = lcc_pkg::TMR_W'(DEB_STEP_CYC - 1);
	localparam lcc_chan_st_t ST_RST = '{lcc_pkg::TMR_ZERO, 1'b0, 1'b0, lcc_pkg::TMR_ZERO,
	                                    4'h0, lcc_pkg::LCC_DB_HIGH, 1'b1};

	lcc_chan_st_t st_r;
	lcc_chan_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Each new bit value restarts the hold; short hold in power-down
		if (ch.evsel_bit != st_r.evsel_tgt) begin
			st_nxt.evsel_tgt = ch.evsel_bit;
			st_nxt.hold_cnt  = ch.power_down ? lcc_pkg::PD_HOLD_CYC - lcc_pkg::TMR_ONE
			                                 : lcc_pkg::HOLD_CYC - lcc_pkg::TMR_ONE;
		end else if (st_r.hold_cnt != lcc_pkg::TMR_ZERO) begin
			st_nxt.hold_cnt = st_r.hold_cnt - lcc_pkg::TMR_ONE;
		end else begin
			st_nxt.evsel_out = st_r.evsel_tgt;
		end

		unique case (st_r.db)
			lcc_pkg::LCC_DB_HIGH: begin
				if (!ch.event_in_n) begin
					if (ch.power_down || ch.deb_bits == 4'h0) begin
						st_nxt.status = 1'b0;
						st_nxt.db     = lcc_pkg::LCC_DB_LOW;
					end else begin
						st_nxt.db       = lcc_pkg::LCC_DB_WAIT;
						st_nxt.deb_mult = ch.deb_bits;
						st_nxt.deb_cnt  = STEP_M1;
					end
				end
			end
			lcc_pkg::LCC_DB_WAIT: begin
				// A glitch that ends before the period leaves the bit set
				if (ch.event_in_n) begin
					st_nxt.db = lcc_pkg::LCC_DB_HIGH;
				end else if (ch.power_down) begin
					st_nxt.status = 1'b0;
					st_nxt.db     = lcc_pkg::LCC_DB_LOW;
				end else if (st_r.deb_cnt != lcc_pkg::TMR_ZERO) begin
					st_nxt.deb_cnt = st_r.deb_cnt - lcc_pkg::TMR_ONE;
				end else if (st_r.deb_mult > lcc_pkg::MULT_ONE) begin
					st_nxt.deb_mult = st_r.deb_mult - lcc_pkg::MULT_ONE;
					st_nxt.deb_cnt  = STEP_M1;
				end else begin
					st_nxt.status = 1'b0;
					st_nxt.db     = lcc_pkg::LCC_DB_LOW;
				end
			end
			lcc_pkg::LCC_DB_LOW: begin
				// Rising edge is never debounced
				if (ch.event_in_n) begin
					st_nxt.status = 1'b1;
					st_nxt.db     = lcc_pkg::LCC_DB_HIGH;
				end
			end
			default: begin
				st_nxt.status = 1'b1;
				st_nxt.db     = lcc_pkg::LCC_DB_HIGH;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= ST_RST;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign ch.evsel_out    = st_r.evsel_out;
	assign ch.event_status = st_r.status;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_evsel_after_hold: assert property ($changed(st_r.evsel_out) |->
		$past(st_r.hold_cnt) == lcc_pkg::TMR_ZERO && $past(i_ce))
		else $error("event select moved before hold expired");
	a_status_rise: assert property ((st_r.db == lcc_pkg::LCC_DB_LOW && ch.event_in_n && i_ce)
		|=> st_r.status)
		else $error("status missed rising event input");
	a_debounce_hold: assert property (($fell(st_r.status) && !$past(ch.power_down)
		&& $past(ch.deb_bits) != 4'h0) |-> $past(st_r.db) == lcc_pkg::LCC_DB_WAIT
		&& $past(st_r.deb_cnt) == lcc_pkg::TMR_ZERO)
		else $error("status cleared before debounce period");
	a_pd_bypass: assert property ((ch.power_down && !ch.event_in_n && i_ce
		&& st_r.db != lcc_pkg::LCC_DB_LOW) |=> !st_r.status)
		else $error("debounce not bypassed in power-down");
	a_hold_restart: assert property ((ch.evsel_bit != st_r.evsel_tgt && i_ce && !ch.power_down)
		|=> st_r.hold_cnt == lcc_pkg::HOLD_CYC - lcc_pkg::TMR_ONE)
		else $error("hold timer not restarted");

	c_glitch_reject: cover property (st_r.db == lcc_pkg::LCC_DB_WAIT
		##1 st_r.db == lcc_pkg::LCC_DB_HIGH);
	c_event_seen: cover property ($fell(st_r.status));
endmodule // lcc_chan

//--- verilog/lcc_top.sv
// Line-chip control port and power-state logic for two channels, APB slave.
// Assumes an APB3 master on the master clock; pin inputs are asynchronous.
//
// Summary of operation
// - Power-down stops both channels; registers kept and still accessible.
// - Power-down overrides per-channel power-save settings.
// - Reset low returns every control register to its default.
// - In power-down the serial transmit output is released to high impedance.
// - 8-bit mode power-save slot sends 0xFF mu-law or 0xD5 A-law.
// - Linear mode power-save slot sends all zeros whatever the law.
// - Idle channel analog outputs released; grounds off when both idle.
// - Three line-chip state outputs follow bits 7..5 of line control.
// - Event select follows its bit after 20 us, or 200 ns in power-down.
// - Battery choice output follows line control bit 3.
// - Auxiliary switch output follows line control bit 4, low means on.
// - Line-chip pins and event input keep working during power-down.
// - Event input mirrors into line control status bit 1.
// - Falling event input is debounced by a programmed period first.
// - Power-down bypasses the event debounce.
// - Mode bits 1 and 0 enable channels 2 and 1; zero is power-save.
// - Linear code select makes the companding-law bit irrelevant.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module lcc_top #(
	parameter int unsigned DEB_STEP_CYC = lcc_pkg::DEB_STEP_CYC
) (
	input  wire logic        I_MCLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_CE,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic        I_POWER_DOWN_N,
	input  wire logic        I_CH1_EVENT_IN_N,
	input  wire logic        I_CH2_EVENT_IN_N,
	input  wire logic [13:0] I_CH1_TX_DATA,
	input  wire logic [13:0] I_CH2_TX_DATA,
	output logic      [2:0]  O_CH1_SLIC_STATE,
	output logic      [2:0]  O_CH2_SLIC_STATE,
	output logic             O_CH1_SLIC_EVENT_SELECT,
	output logic             O_CH2_SLIC_EVENT_SELECT,
	output logic             O_CH1_BATTERY_CHOICE,
	output logic             O_CH2_BATTERY_CHOICE,
	output logic             O_CH1_AUX_SWITCH_N,
	output logic             O_CH2_AUX_SWITCH_N,
	output logic      [13:0] O_CH1_SLOT_DATA,
	output logic      [13:0] O_CH2_SLOT_DATA,
	output logic             O_SERIAL_TX_OUT_OE_N,
	output logic             O_CH1_TX_AMP_OUT_EN,
	output logic             O_CH2_TX_AMP_OUT_EN,
	output logic             O_CH1_RECEIVE_ANALOG_OUT_EN,
	output logic             O_CH2_RECEIVE_ANALOG_OUT_EN,
	output logic             O_SIGNAL_GROUND_OUT_EN,
	output logic             O_INTERNAL_GROUND_REF_ACTIVE
);
	typedef struct packed {
		logic             pd_s1;
		logic             pd_s2;
		logic [1:0]       ev_s1;
		logic [1:0]       ev_s2;
		logic [7:0]       mode;
		logic [7:0]       debt;
		logic [1:0][7:0]  lc;
		logic [31:0]      prdata;
		logic [1:0][13:0] slot;
		logic             tx_oe_n;
		logic [1:0]       an_en;
		logic             gnd_en;
		logic             ref_act;
	} lcc_top_st_t;

	// Power-down assumed until the pin has been sampled; outputs start released
	localparam lcc_top_st_t ST_RST = '{1'b0, 1'b0, 2'b11, 2'b11, lcc_pkg::MODE_RST,
	                                   lcc_pkg::DEBT_RST, {lcc_pkg::LC_RST, lcc_pkg::LC_RST},
	                                   32'h00000000, {lcc_pkg::LIN_IDLE, lcc_pkg::LIN_IDLE},
	                                   1'b1, 2'b00, 1'b0, 1'b0};

	lcc_top_st_t st_r;
	lcc_top_st_t st_nxt;
	logic        pd_w;
	logic        apb_setup;
	logic        apb_wr;
	logic        hit_w;
	logic [1:0]  status_w;
	logic [1:0]  evsel_w;
	logic [1:0]  ch_on_w;

	lcc_ch_if ch_if [2] ();

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == lcc_pkg::OFF_MODE) || (a == lcc_pkg::OFF_DEBT) ||
		           (a == lcc_pkg::OFF_LC1) || (a == lcc_pkg::OFF_LC2);
	endfunction

	assign pd_w      = !st_r.pd_s2;
	assign apb_setup = I_PSEL && !I_PENABLE;
	assign apb_wr    = I_PSEL && I_PENABLE && I_PWRITE;
	assign hit_w     = addr_hit(I_PADDR);
	// Mode bit per channel, forced off by power-down
	assign ch_on_w   = st_r.mode[lcc_pkg::MODE_CH2_ACT:lcc_pkg::MODE_CH1_ACT]
	                   & {2{!pd_w}};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			localparam int DLSB = (g == 0) ? lcc_pkg::DEBT_CH1_LSB : lcc_pkg::DEBT_CH2_LSB;
			assign ch_if[g].power_down = pd_w;
			assign ch_if[g].evsel_bit  = st_r.lc[g][lcc_pkg::LC_EVSEL];
			assign ch_if[g].deb_bits   = st_r.debt[DLSB +: 4];
			assign ch_if[g].event_in_n = st_r.ev_s2[g];
			assign status_w[g]         = ch_if[g].event_status;
			assign evsel_w[g]          = ch_if[g].evsel_out;
			lcc_chan #(
				.DEB_STEP_CYC (DEB_STEP_CYC)
			) u_chan (
				.i_clk   (I_MCLK),
				.i_rst_n (I_RESETN),
				.i_ce    (I_CE),
				.ch      (ch_if[g])
			);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		// Pin synchronisers
		st_nxt.pd_s1 = I_POWER_DOWN_N;
		st_nxt.pd_s2 = st_r.pd_s1;
		st_nxt.ev_s1 = {I_CH2_EVENT_IN_N, I_CH1_EVENT_IN_N};
		st_nxt.ev_s2 = st_r.ev_s1;

		// Register access stays alive in every power state
		if (apb_wr) begin
			case (I_PADDR)
				lcc_pkg::OFF_MODE: st_nxt.mode  = I_PWDATA[7:0];
				lcc_pkg::OFF_DEBT: st_nxt.debt  = I_PWDATA[7:0];
				lcc_pkg::OFF_LC1:  st_nxt.lc[0] = I_PWDATA[7:0];
				lcc_pkg::OFF_LC2:  st_nxt.lc[1] = I_PWDATA[7:0];
				default:           st_nxt.mode  = st_r.mode;
			endcase
		end
		// Read data taken in setup so it stands through the access phase
		if (apb_setup) begin
			case (I_PADDR)
				lcc_pkg::OFF_MODE: st_nxt.prdata = {24'h000000, st_r.mode};
				lcc_pkg::OFF_DEBT: st_nxt.prdata = {24'h000000, st_r.debt};
				lcc_pkg::OFF_LC1:  st_nxt.prdata = {24'h000000, st_r.lc[0][7:2],
				                                    status_w[0], 1'b0};
				lcc_pkg::OFF_LC2:  st_nxt.prdata = {24'h000000, st_r.lc[1][7:2],
				                                    status_w[1], 1'b0};
				default:           st_nxt.prdata = 32'h00000000;
			endcase
		end

		// Transmit slot contents; power-save channels send the idle code
		for (int c = 0; c < 2; c++) begin
			if (ch_on_w[c]) begin
				st_nxt.slot[c] = (c == 0) ? I_CH1_TX_DATA : I_CH2_TX_DATA;
			end else if (st_r.mode[lcc_pkg::MODE_LIN]) begin
				st_nxt.slot[c] = lcc_pkg::LIN_IDLE;
			end else if (st_r.mode[lcc_pkg::MODE_A_LAW_SEL]) begin
				st_nxt.slot[c] = {lcc_pkg::PAD8, lcc_pkg::A_IDLE};
			end else begin
				st_nxt.slot[c] = {lcc_pkg::PAD8, lcc_pkg::MU_IDLE};
			end
		end

		// Serial output stays driven in power-save, released only in power-down; analog outputs follow the channel enables
		st_nxt.tx_oe_n = pd_w;
		st_nxt.an_en   = ch_on_w;
		st_nxt.gnd_en  = |ch_on_w;
		st_nxt.ref_act = |ch_on_w;
	end

	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st_r <= ST_RST;
		end else if (I_CE) begin
			st_r <= st_nxt;
		end
	end

	assign O_PRDATA  = st_r.prdata;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !hit_w;

	// Line-chip pins come from register flops, event select from the hold timer (shorter in power-down); all work in any power state
	assign O_CH1_SLIC_STATE        = st_r.lc[0][lcc_pkg::LC_STATE_LSB +: 3];
	assign O_CH2_SLIC_STATE        = st_r.lc[1][lcc_pkg::LC_STATE_LSB +: 3];
	assign O_CH1_SLIC_EVENT_SELECT = evsel_w[0];
	assign O_CH2_SLIC_EVENT_SELECT = evsel_w[1];
	assign O_CH1_BATTERY_CHOICE    = st_r.lc[0][lcc_pkg::LC_BATT];
	assign O_CH2_BATTERY_CHOICE    = st_r.lc[1][lcc_pkg::LC_BATT];
	assign O_CH1_AUX_SWITCH_N      = st_r.lc[0][lcc_pkg::LC_AUXSW];
	assign O_CH2_AUX_SWITCH_N      = st_r.lc[1][lcc_pkg::LC_AUXSW];

	assign O_CH1_SLOT_DATA              = st_r.slot[0];
	assign O_CH2_SLOT_DATA              = st_r.slot[1];
	assign O_SERIAL_TX_OUT_OE_N         = st_r.tx_oe_n;
	assign O_CH1_TX_AMP_OUT_EN          = st_r.an_en[0];
	assign O_CH2_TX_AMP_OUT_EN          = st_r.an_en[1];
	assign O_CH1_RECEIVE_ANALOG_OUT_EN  = st_r.an_en[0];
	assign O_CH2_RECEIVE_ANALOG_OUT_EN  = st_r.an_en[1];
	assign O_SIGNAL_GROUND_OUT_EN       = st_r.gnd_en;
	assign O_INTERNAL_GROUND_REF_ACTIVE = st_r.ref_act;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);

	a_pd_regs_kept: assert property ((pd_w && I_CE && !apb_wr) |=> $stable(st_r.mode)
		&& $stable(st_r.lc))
		else $error("registers changed in power-down without a write");
	a_pd_over_save: assert property ((pd_w && I_CE) |=> st_r.an_en == 2'b00
		&& !st_r.gnd_en)
		else $error("channel powered during power-down");
	a_reset_defaults: assert property (@(posedge I_MCLK) disable iff (1'b0)
		!I_RESETN |-> st_r.mode == lcc_pkg::MODE_RST && st_r.debt == lcc_pkg::DEBT_RST
		&& st_r.lc == {lcc_pkg::LC_RST, lcc_pkg::LC_RST})
		else $error("register not at default under reset");
	a_pd_tx_release: assert property ((pd_w && I_CE) |=> st_r.tx_oe_n)
		else $error("serial output driven in power-down");
	a_save_mu_code: assert property ((I_CE && !pd_w && !st_r.mode[lcc_pkg::MODE_CH1_ACT]
		&& !st_r.mode[lcc_pkg::MODE_LIN] && !st_r.mode[lcc_pkg::MODE_A_LAW_SEL])
		|=> O_CH1_SLOT_DATA == {lcc_pkg::PAD8, lcc_pkg::MU_IDLE})
		else $error("wrong mu-law power-save code");
	a_save_a_code: assert property ((I_CE && !pd_w && !st_r.mode[lcc_pkg::MODE_CH2_ACT]
		&& !st_r.mode[lcc_pkg::MODE_LIN] && st_r.mode[lcc_pkg::MODE_A_LAW_SEL])
		|=> O_CH2_SLOT_DATA == {lcc_pkg::PAD8, lcc_pkg::A_IDLE})
		else $error("wrong A-law power-save code");
	a_lin_ignores_law: assert property ((I_CE && !pd_w && !st_r.mode[lcc_pkg::MODE_CH2_ACT]
		&& st_r.mode[lcc_pkg::MODE_LIN]) |=> O_CH2_SLOT_DATA == lcc_pkg::LIN_IDLE)
		else $error("linear power-save slot not zero");
	a_active_data: assert property ((I_CE && !pd_w && st_r.mode[lcc_pkg::MODE_CH1_ACT])
		|=> O_CH1_SLOT_DATA == $past(I_CH1_TX_DATA) && O_CH1_TX_AMP_OUT_EN)
		else $error("active channel not passing data");
	a_idle_ground: assert property ((I_CE && st_r.mode[1:0] == 2'b00) |=> !O_SIGNAL_GROUND_OUT_EN
		&& !O_INTERNAL_GROUND_REF_ACTIVE)
		else $error("grounds active with both channels off");
	a_state_write: assert property ((apb_wr && I_CE && I_PADDR == lcc_pkg::OFF_LC1)
		|=> O_CH1_SLIC_STATE == $past(I_PWDATA[7:5]))
		else $error("state pins not following write");
	a_batt_write: assert property ((apb_wr && I_CE && I_PADDR == lcc_pkg::OFF_LC2)
		|=> O_CH2_BATTERY_CHOICE == $past(I_PWDATA[3]))
		else $error("battery choice not following write");
	a_aux_write: assert property ((apb_wr && I_CE && I_PADDR == lcc_pkg::OFF_LC1)
		|=> O_CH1_AUX_SWITCH_N == $past(I_PWDATA[4]))
		else $error("aux switch not following write");
	a_pd_pins_live: assert property ((pd_w && apb_wr && I_CE && I_PADDR == lcc_pkg::OFF_LC2)
		|=> O_CH2_SLIC_STATE == $past(I_PWDATA[7:5]))
		else $error("state pins frozen in power-down");

	c_pd_entry: cover property ($rose(pd_w));
	c_save_code: cover property (!pd_w && st_r.mode[1:0] == 2'b01 ##1 O_CH2_SLOT_DATA
		== {lcc_pkg::PAD8, lcc_pkg::MU_IDLE});
	c_evsel_move: cover property ($changed(O_CH1_SLIC_EVENT_SELECT));
endmodule // lcc_top

//--- test/lcc_slic_model.sv
// Behavioural line chip for one channel: reports a detected event.
// Assumes state and event-select pins come straight from the control block.
`timescale 1ns/1ps
module lcc_slic_model (
	input  wire logic       i_off_hook,
	input  wire logic [2:0] i_state,
	input  wire logic       i_evsel,
	output logic            o_event_in_n
);
	logic ringing;
	// Ground-key faults are not modelled, so that detector never fires
	always_comb begin
		ringing      = (i_state == 3'b010) || (i_state == 3'b100);
		o_event_in_n = 1'b1;
		if (i_state != 3'b111) begin
			o_event_in_n = !(i_off_hook && (ringing || i_evsel));
		end
	end
endmodule // lcc_slic_model

//--- test/tb_slic_control_and_power_state.sv
// Self-checking bench of the line-chip control block, driven over APB.
// Assumes two behavioural line chips and a shortened debounce step.
`timescale 1ns/1ps
module tb_slic_control_and_power_state;
	localparam int unsigned STEP = 4;
	logic        clk     = 1'b0;
	logic        rst_n   = 1'b1;
	logic        psel    = 1'b0;
	logic        pen     = 1'b0;
	logic        pwr     = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h00000000;
	logic        pd_n    = 1'b1;
	logic [1:0]  hook    = 2'h0;
	logic [13:0] tx1     = 14'h0000;
	logic [13:0] tx2     = 14'h0000;
	logic [31:0] prdata;
	logic        pready, pslverr, ev1_n, ev2_n, evs1, evs2, bat1, bat2, aux1, aux2;
	logic        oe_n, amp1, amp2, rcv1, rcv2, sg_en, ref_act;
	logic [2:0]  st1, st2;
	logic [13:0] slot1, slot2;
	int          n_mismatch = 0;
	int          tests_run  = 0;

	always #5 clk = ~clk;

	lcc_top #(.DEB_STEP_CYC(STEP)) DUT (
		.I_MCLK(clk), .I_RESETN(rst_n), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_POWER_DOWN_N(pd_n),
		.I_CH1_EVENT_IN_N(ev1_n), .I_CH2_EVENT_IN_N(ev2_n), .I_CH1_TX_DATA(tx1),
		.I_CH2_TX_DATA(tx2), .O_CH1_SLIC_STATE(st1), .O_CH2_SLIC_STATE(st2),
		.O_CH1_SLIC_EVENT_SELECT(evs1), .O_CH2_SLIC_EVENT_SELECT(evs2),
		.O_CH1_BATTERY_CHOICE(bat1), .O_CH2_BATTERY_CHOICE(bat2),
		.O_CH1_AUX_SWITCH_N(aux1), .O_CH2_AUX_SWITCH_N(aux2), .O_CH1_SLOT_DATA(slot1),
		.O_CH2_SLOT_DATA(slot2), .O_SERIAL_TX_OUT_OE_N(oe_n), .O_CH1_TX_AMP_OUT_EN(amp1),
		.O_CH2_TX_AMP_OUT_EN(amp2), .O_CH1_RECEIVE_ANALOG_OUT_EN(rcv1),
		.O_CH2_RECEIVE_ANALOG_OUT_EN(rcv2), .O_SIGNAL_GROUND_OUT_EN(sg_en),
		.O_INTERNAL_GROUND_REF_ACTIVE(ref_act));

	lcc_slic_model u_line1 (.i_off_hook(hook[0]), .i_state(st1), .i_evsel(evs1),
		.o_event_in_n(ev1_n));
	lcc_slic_model u_line2 (.i_off_hook(hook[1]), .i_state(st2), .i_evsel(evs2),
		.o_event_in_n(ev2_n));

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		if (k >= 64) begin
			n_mismatch++;
			close_out();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {24'h000000, d}, q, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h00000000, q, e);
	endtask

	// Counts edges until event select reaches the target level
	task automatic hold_cnt(input logic tgt, input int exp);
		int k;
		k = 0;
		while (evs1 !== tgt && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 3000) begin
			n_mismatch++;
			close_out();
		end
		chk(32'(k), 32'(exp));
	endtask

	function automatic logic [13:0] slot_exp(input logic [3:0] m, input logic act,
		input logic [13:0] tx);
		// Active channels pass the whole transmit word in every mode
		if (act) return tx;
		if (m[3]) return 14'h0000;
		return m[2] ? 14'h00D5 : 14'h00FF;
	endfunction

	initial begin
		logic [31:0] q;
		logic [7:0]  v;
		logic        e;
		int          seed;
		seed = $urandom(67);
		// A real falling edge, so the asynchronous reset takes hold at once
		rst_n <= 1'b0;
		cyc(5);
		chk({31'h0, oe_n}, 32'h00000001);
		chk({4'h0, slot2, slot1}, 32'h00000000);
		rst_n <= 1'b1;
		cyc(4);
		rd(lcc_pkg::OFF_MODE, q);
		chk(q, 32'h00000000);
		rd(lcc_pkg::OFF_DEBT, q);
		chk(q, 32'h00000000);
		rd(lcc_pkg::OFF_LC1, q);
		chk(q, 32'h00000002);
		apb(1'b0, 12'h010, 32'h00000000, q, e);
		chk({q[30:0], e}, 32'h00000001);
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom()) & 8'hFB;
			wr(i[0] ? lcc_pkg::OFF_LC2 : lcc_pkg::OFF_LC1, v);
			cyc(2);
			chk(32'(i[0] ? {st2, aux2, bat2} : {st1, aux1, bat1}), 32'(v[7:3]));
			rd(i[0] ? lcc_pkg::OFF_LC2 : lcc_pkg::OFF_LC1, q);
			chk(q, {24'h000000, v[7:2], 2'b10});
		end
		for (int m = 0; m < 16; m++) begin
			tx1 <= 14'($urandom());
			tx2 <= 14'($urandom());
			wr(lcc_pkg::OFF_MODE, 8'(m));
			cyc(3);
			q = 32'({slot_exp(m[3:0], m[1], tx2), slot_exp(m[3:0], m[0], tx1)});
			chk(32'({slot2, slot1}), q);
			q = 32'({1'b0, {2{m[1]}}, {2{m[0]}}, {2{|m[1:0]}}});
			chk(32'({oe_n, amp2, rcv2, amp1, rcv1, sg_en, ref_act}), q);
		end
		wr(lcc_pkg::OFF_MODE, 8'h0B);
		pd_n <= 1'b0;
		cyc(4);
		chk(32'({oe_n, amp2, rcv2, amp1, rcv1, sg_en, ref_act}), 32'h00000040);
		rd(lcc_pkg::OFF_MODE, q);
		chk(q, 32'h0000000B);
		wr(lcc_pkg::OFF_LC1, 8'h24);
		hold_cnt(1'b1, 21);
		chk(32'(st1), 32'h00000001);
		wr(lcc_pkg::OFF_DEBT, 8'h33);
		wr(lcc_pkg::OFF_LC2, 8'h80);
		hook[1] <= 1'b1;
		cyc(4);
		rd(lcc_pkg::OFF_LC2, q);
		chk(q, 32'h00000080);
		hook[1] <= 1'b0;
		pd_n    <= 1'b1;
		cyc(4);
		wr(lcc_pkg::OFF_LC1, 8'h80);
		hold_cnt(1'b0, 2001);
		// Ringing state senses ring trip whatever event select says
		hook[0] <= 1'b1;
		cyc(4);
		rd(lcc_pkg::OFF_LC1, q);
		chk(q, 32'h00000082);
		cyc(20);
		rd(lcc_pkg::OFF_LC1, q);
		chk(q, 32'h00000080);
		hook[0] <= 1'b0;
		cyc(6);
		rd(lcc_pkg::OFF_LC1, q);
		chk(q, 32'h00000082);
		hook[0] <= 1'b1;
		cyc(3);
		hook[0] <= 1'b0;
		cyc(20);
		rd(lcc_pkg::OFF_LC1, q);
		chk(q, 32'h00000082);
		close_out();
	end
endmodule // tb_slic_control_and_power_state
